// ### verilog/gio_top.sv
`timescale 1ns/10ps
`include "gio_defs.svh"

// How it works
// - Two byte ports, third has two pins
// - Input pin reads sample live pins, no latch
// - Output latch holds until next write
// - Per-pin pull-up enable, resets to zero
// - Pull-up only where pin function allows, either direction
// - Second port pins three, four: fixed pull-up
// - Second port pin five: fixed pull-down
// - Falling edge on port A wakes device
// - Per-pin wake enable, resets to zero
// - Wake only for GPIO inputs in low power
// - Power-on sets data, direction all ones
// - Low-power watchdog leaves port registers alone
// - Direction one is input, zero drives
// - Output pins read back the latch
module gio_top (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_wdt_timeout,
  input  gio_pkg::gio_power_mode_t      i_power_mode,
  input  wire logic [`GIO_ADDR_W-1:0]   i_addr,
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  input  wire logic [7:0]               i_wdata,
  output logic      [7:0]               o_rdata,
  input  wire logic [7:0]               i_port_a_pin,
  input  wire logic [7:0]               i_port_a_pu_allow,
  input  wire logic [7:0]               i_port_a_gpio_sel,
  output logic      [7:0]               o_port_a_out,
  output logic      [7:0]               o_port_a_oe,
  output logic      [7:0]               o_port_a_pullup,
  input  wire logic [7:0]               i_port_b_pin,
  input  wire logic [7:0]               i_port_b_pu_allow,
  output logic      [7:0]               o_port_b_out,
  output logic      [7:0]               o_port_b_oe,
  output logic      [7:0]               o_port_b_pullup,
  output logic      [7:0]               o_port_b_fixed_pullup,
  output logic      [7:0]               o_port_b_fixed_pulldown,
  input  wire logic [1:0]               i_port_c_pin,
  input  wire logic [1:0]               i_port_c_pu_allow,
  output logic      [1:0]               o_port_c_out,
  output logic      [1:0]               o_port_c_oe,
  output logic      [1:0]               o_port_c_pullup,
  output logic                          o_wake_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and reset qualification

  localparam logic [7:0] RstWake = `GIO_RST_WAKE;

  logic       low_power;
  logic       wdt_rst;
  logic [7:0] wake_q;
  logic [7:0] wake_d;
  logic [7:0] wake_arm;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] a_rd_data;
  logic [7:0] a_rd_dir;
  logic [7:0] a_rd_pu;
  logic [7:0] a_dir;
  logic [7:0] b_rd_data;
  logic [7:0] b_rd_dir;
  logic [7:0] b_rd_pu;
  logic [7:0] c_rd_data;
  logic [7:0] c_rd_dir;
  logic [7:0] c_rd_pu;

  // Write strobe for one register index
  function automatic logic wr_hit(input logic [`GIO_ADDR_W-1:0] addr,
                                  input logic                   wr,
                                  input logic [`GIO_ADDR_W-1:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction : wr_hit

  assign low_power = (i_power_mode == gio_pkg::gio_mode_idle) ||
                     (i_power_mode == gio_pkg::gio_mode_sleep);

  // watchdog in idle or sleep is ignored here
  // watchdog in fast or slow acts as reset
  assign wdt_rst = i_wdt_timeout && !low_power;

  ////////////////////////////////////////////////////////////////////////////
  // The three ports

  gio_port #(.W(8)) u_port_a (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_wdt_rst  (wdt_rst),
    .i_wr_data  (wr_hit(i_addr, i_wr_en, `GIO_OFS_A_DATA)),
    .i_wr_dir   (wr_hit(i_addr, i_wr_en, `GIO_OFS_A_DIR)),
    .i_wr_pu    (wr_hit(i_addr, i_wr_en, `GIO_OFS_A_PU)),
    .i_wdata    (i_wdata),
    .i_pin      (i_port_a_pin),
    .i_pu_allow (i_port_a_pu_allow),
    .o_out      (o_port_a_out),
    .o_oe       (o_port_a_oe),
    .o_pullup   (o_port_a_pullup),
    .o_dir      (a_dir),
    .o_rd_data  (a_rd_data),
    .o_rd_dir   (a_rd_dir),
    .o_rd_pu    (a_rd_pu)
  );

  gio_port #(.W(8)) u_port_b (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_wdt_rst  (wdt_rst),
    .i_wr_data  (wr_hit(i_addr, i_wr_en, `GIO_OFS_B_DATA)),
    .i_wr_dir   (wr_hit(i_addr, i_wr_en, `GIO_OFS_B_DIR)),
    .i_wr_pu    (wr_hit(i_addr, i_wr_en, `GIO_OFS_B_PU)),
    .i_wdata    (i_wdata),
    .i_pin      (i_port_b_pin),
    .i_pu_allow (i_port_b_pu_allow),
    .o_out      (o_port_b_out),
    .o_oe       (o_port_b_oe),
    .o_pullup   (o_port_b_pullup),
    .o_dir      (),
    .o_rd_data  (b_rd_data),
    .o_rd_dir   (b_rd_dir),
    .o_rd_pu    (b_rd_pu)
  );

  // third port carries two pins only
  gio_port #(.W(2)) u_port_c (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_wdt_rst  (wdt_rst),
    .i_wr_data  (wr_hit(i_addr, i_wr_en, `GIO_OFS_C_DATA)),
    .i_wr_dir   (wr_hit(i_addr, i_wr_en, `GIO_OFS_C_DIR)),
    .i_wr_pu    (wr_hit(i_addr, i_wr_en, `GIO_OFS_C_PU)),
    .i_wdata    (i_wdata),
    .i_pin      (i_port_c_pin),
    .i_pu_allow (i_port_c_pu_allow),
    .o_out      (o_port_c_out),
    .o_oe       (o_port_c_oe),
    .o_pullup   (o_port_c_pullup),
    .o_dir      (),
    .o_rd_data  (c_rd_data),
    .o_rd_dir   (c_rd_dir),
    .o_rd_pu    (c_rd_pu)
  );

  // fixed pull-ups, wired beside the switched ones
  assign o_port_b_fixed_pullup = `GIO_B_FIXED_PU;
  // fixed pull-down, cost of pull-up is the user's
  assign o_port_b_fixed_pulldown = `GIO_B_FIXED_PD;

  ////////////////////////////////////////////////////////////////////////////
  // Port A wake enables and detector

  // wake enables, cleared by any full reset
  always_comb begin
    wake_d = wake_q;
    if (!i_rst_b || wdt_rst) begin
      wake_d = RstWake;
    end else if (wr_hit(i_addr, i_wr_en, `GIO_OFS_A_WAKE)) begin
      wake_d = i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    wake_q <= wake_d;
  end

  assign wake_arm = wake_q & a_dir & i_port_a_gpio_sel;

  // detector only fires while in idle or sleep
  gio_wake #(.W(8)) u_wake (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_pin       (i_port_a_pin),
    .i_arm       (wake_arm),
    .i_low_power (low_power),
    .o_wake_req  (o_wake_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Read captures pins in the read cycle; idle keeps last value
  always_comb begin
    rdata_d = rdata_q;
    if (!i_rst_b) begin
      rdata_d = `GIO_RD_IDLE;
    end else if (i_rd_en) begin
      case (i_addr)
        `GIO_OFS_A_DATA: rdata_d = a_rd_data;
        `GIO_OFS_A_DIR:  rdata_d = a_rd_dir;
        `GIO_OFS_A_PU:   rdata_d = a_rd_pu;
        `GIO_OFS_A_WAKE: rdata_d = wake_q;
        `GIO_OFS_B_DATA: rdata_d = b_rd_data;
        `GIO_OFS_B_DIR:  rdata_d = b_rd_dir;
        `GIO_OFS_B_PU:   rdata_d = b_rd_pu;
        `GIO_OFS_C_DATA: rdata_d = c_rd_data;
        `GIO_OFS_C_DIR:  rdata_d = c_rd_dir;
        `GIO_OFS_C_PU:   rdata_d = c_rd_pu;
        default:         rdata_d = `GIO_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock);
  endclocking

  chk_c_upper_zero: assert property (
    i_rst_b && i_rd_en && i_addr == `GIO_OFS_C_DATA |=> o_rdata[7:2] == 6'h0)
    else $error("third port upper bits not zero");

  chk_read_live_pin: assert property (
    i_rst_b && i_rd_en && !i_wr_en && i_addr == `GIO_OFS_A_DATA &&
    o_port_a_oe == 8'h00 |=> o_rdata == $past(i_port_a_pin))
    else $error("input read does not show live pins");

  chk_latch_holds: assert property (
    i_rst_b && !i_wdt_timeout &&
    !(i_wr_en && i_addr == `GIO_OFS_A_DATA) |=> $stable(o_port_a_out))
    else $error("output latch changed without write");

  chk_pullup_reset: assert property (
    !i_rst_b |=> o_port_a_pullup == 8'h00 && o_port_b_pullup == 8'h00 &&
    o_port_c_pullup == 2'h0)
    else $error("pull-up enabled after reset");

  chk_pullup_gate: assert property (
    (o_port_b_pullup & ~i_port_b_pu_allow) == 8'h00)
    else $error("pull-up on a pin whose function forbids it");

  chk_fixed_pullup: assert property (
    o_port_b_fixed_pullup[4:3] == 2'h3)
    else $error("fixed pull-ups missing");

  chk_fixed_pulldown: assert property (
    o_port_b_fixed_pulldown[5] && !o_port_b_fixed_pullup[5])
    else $error("fixed pull-down missing");

  chk_wake_low_power: assert property (
    disable iff (!i_rst_b) o_wake_req |-> $past(low_power))
    else $error("wake request outside low power");

  chk_wake_en_reset: assert property (
    !i_rst_b |=> wake_q == 8'h00)
    else $error("wake enables not cleared");

  chk_wake_armed: assert property (
    disable iff (!i_rst_b) o_wake_req |-> $past(|wake_arm))
    else $error("wake request with no armed pin");

  chk_por_inputs: assert property (
    !i_rst_b |=> o_port_a_oe == 8'h00 && o_port_b_oe == 8'h00 &&
    o_port_c_oe == 2'h0 && o_port_a_out == 8'hff && o_port_c_out == 2'h3)
    else $error("ports not inputs after power-on");

  chk_sleep_wdt_keep: assert property (
    i_rst_b && i_wdt_timeout && low_power && !i_wr_en |=>
    $stable(o_port_a_out) && $stable(o_port_b_oe) && $stable(wake_q))
    else $error("low-power watchdog disturbed ports");

  chk_dir_write: assert property (
    i_rst_b && !i_wdt_timeout && i_wr_en && i_addr == `GIO_OFS_A_DIR |=>
    o_port_a_oe == ~$past(i_wdata))
    else $error("direction write not reflected on enables");

  chk_out_readback: assert property (
    i_rst_b && i_rd_en && !i_wr_en && i_addr == `GIO_OFS_A_DATA &&
    o_port_a_oe == 8'hff |=> o_rdata == $past(o_port_a_out))
    else $error("output read does not show latch");

  chk_wake_single: assert property (
    disable iff (!i_rst_b) o_wake_req |=> !o_wake_req)
    else $error("wake request longer than one cycle");

  chk_run_wdt_reset: assert property (
    i_rst_b && i_wdt_timeout && !low_power |=> o_port_b_oe == 8'h00 &&
    o_port_a_out == 8'hff && o_port_a_pullup == 8'h00 && wake_q == 8'h00)
    else $error("run-mode watchdog did not restore ports");

  cov_wake: cover property (o_wake_req);
  cov_input_read: cover property (
    i_rd_en && i_addr == `GIO_OFS_A_DATA && o_port_a_oe == 8'h00);
  cov_sleep_wdt: cover property (i_rst_b && i_wdt_timeout && low_power);

endmodule : gio_top

// ### common/gio_defs.svh
`ifndef GIO_DEFS_SVH
`define GIO_DEFS_SVH

// Register indices on the data-memory port
`define GIO_ADDR_W        4
`define GIO_OFS_A_DATA    4'h0
`define GIO_OFS_A_DIR     4'h1
`define GIO_OFS_A_PU      4'h2
`define GIO_OFS_A_WAKE    4'h3
`define GIO_OFS_B_DATA    4'h4
`define GIO_OFS_B_DIR     4'h5
`define GIO_OFS_B_PU      4'h6
`define GIO_OFS_C_DATA    4'h7
`define GIO_OFS_C_DIR     4'h8
`define GIO_OFS_C_PU      4'h9

// Reset values, sliced to each port's width
`define GIO_RST_DATA      8'hff
`define GIO_RST_DIR       8'hff
`define GIO_RST_PULLUP    8'h00
`define GIO_RST_WAKE      8'h00
`define GIO_RD_IDLE       8'h00

// Fixed resistors on the second port
`define GIO_B_FIXED_PU    8'h18
`define GIO_B_FIXED_PD    8'h20

`endif

// ### common/gio_pkg.sv
package gio_pkg;

  // Power mode reported by the mode controller
  typedef enum logic [1:0] {
    gio_mode_fast,
    gio_mode_slow,
    gio_mode_idle,
    gio_mode_sleep
  } gio_power_mode_t;

  // Wake detector state
  typedef enum logic [1:0] {
    gio_wk_off,
    gio_wk_armed,
    gio_wk_fired
  } gio_wake_state_t;

endpackage : gio_pkg

// ### verilog/gio_port.sv
`timescale 1ns/10ps
`include "gio_defs.svh"

module gio_port #(
  parameter int W = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic         i_wdt_rst,
  input  wire logic         i_wr_data,
  input  wire logic         i_wr_dir,
  input  wire logic         i_wr_pu,
  input  wire logic [7:0]   i_wdata,
  input  wire logic [W-1:0] i_pin,
  input  wire logic [W-1:0] i_pu_allow,
  output logic      [W-1:0] o_out,
  output logic      [W-1:0] o_oe,
  output logic      [W-1:0] o_pullup,
  output logic      [W-1:0] o_dir,
  output logic      [7:0]   o_rd_data,
  output logic      [7:0]   o_rd_dir,
  output logic      [7:0]   o_rd_pu
);

  localparam logic [7:0] RstData = `GIO_RST_DATA;
  localparam logic [7:0] RstDir  = `GIO_RST_DIR;
  localparam logic [7:0] RstPu   = `GIO_RST_PULLUP;

  if (W < 1 || W > 8) begin : g_bad_width
    $error("gio_port: width must be 1 to 8");
  end

  logic [W-1:0] data_q;
  logic [W-1:0] data_d;
  logic [W-1:0] dir_q;
  logic [W-1:0] dir_d;
  logic [W-1:0] pu_q;
  logic [W-1:0] pu_d;

  // Inputs show the live pin, outputs show the latch
  function automatic logic [W-1:0] pin_view(input logic [W-1:0] dir,
                                            input logic [W-1:0] latch,
                                            input logic [W-1:0] pin);
    pin_view = (dir & pin) | (~dir & latch);
  endfunction : pin_view

  // Next register values; a power-on or run-mode watchdog reset wins
  always_comb begin
    data_d = data_q;
    dir_d  = dir_q;
    pu_d   = pu_q;
    if (!i_rst_b || i_wdt_rst) begin
      data_d = RstData[W-1:0];
      dir_d  = RstDir[W-1:0];
      pu_d   = RstPu[W-1:0];
    end else begin
      if (i_wr_data) begin
        data_d = i_wdata[W-1:0];
      end
      if (i_wr_dir) begin
        dir_d = i_wdata[W-1:0];
      end
      if (i_wr_pu) begin
        pu_d = i_wdata[W-1:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    data_q <= data_d;
    dir_q  <= dir_d;
    pu_q   <= pu_d;
  end

  // Pad controls and readback
  assign o_out = data_q;
  assign o_oe = ~dir_q;
  // pull-up only where the pin function allows
  assign o_pullup = pu_q & i_pu_allow;
  assign o_dir = dir_q;
  // live pin, not latched; latch for outputs
  assign o_rd_data = 8'(pin_view(dir_q, data_q, i_pin));
  assign o_rd_dir = 8'(dir_q);
  assign o_rd_pu = 8'(pu_q);

endmodule : gio_port

// ### verilog/gio_wake.sv
`timescale 1ns/10ps

module gio_wake #(
  parameter int W = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_pin,
  input  wire logic [W-1:0] i_arm,
  input  wire logic         i_low_power,
  output logic              o_wake_req
);

  if (W < 1) begin : g_bad_width
    $error("gio_wake: width must be at least 1");
  end

  logic [W-1:0]               sync1_q;
  logic [W-1:0]               sync1_d;
  logic [W-1:0]               sync2_q;
  logic [W-1:0]               sync2_d;
  logic [W-1:0]               prev_q;
  logic [W-1:0]               prev_d;
  logic                       req_q;
  logic                       req_d;
  logic [W-1:0]               fall;
  gio_pkg::gio_wake_state_t   state_q;
  gio_pkg::gio_wake_state_t   state_d;

  assign fall = prev_q & ~sync2_q & i_arm;

  // Sync chain resets high so a released reset sees no false edge
  always_comb begin
    sync1_d = i_pin;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    state_d = state_q;
    req_d   = 1'b0;
    if (!i_rst_b) begin
      sync1_d = '1;
      sync2_d = '1;
      prev_d  = '1;
      state_d = gio_pkg::gio_wk_off;
    end else begin
      case (state_q)
        gio_pkg::gio_wk_off: begin
          if (i_low_power) begin
            state_d = gio_pkg::gio_wk_armed;
          end
        end
        gio_pkg::gio_wk_armed: begin
          if (!i_low_power) begin
            state_d = gio_pkg::gio_wk_off;
          // one request per stay in low power
          end else if (|fall) begin
            req_d   = 1'b1;
            state_d = gio_pkg::gio_wk_fired;
          end
        end
        gio_pkg::gio_wk_fired: begin
          if (!i_low_power) begin
            state_d = gio_pkg::gio_wk_off;
          end
        end
        default: begin
          state_d = gio_pkg::gio_wk_off;
        end
      endcase
    end
  end

  // two-stage synchroniser, edge seen past it
  always_ff @(posedge i_clock) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    prev_q  <= prev_d;
    state_q <= state_d;
    req_q   <= req_d;
  end

  assign o_wake_req = req_q;

endmodule : gio_wake

// ### tb/gio_pin_model.sv
`timescale 1ns/10ps

module gio_pin_model #(
  parameter int W = 8
) (
  input  wire logic         i_clock,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_pullup,
  input  wire logic [W-1:0] i_fixed_pu,
  input  wire logic [W-1:0] i_fixed_pd,
  input  wire logic [W-1:0] i_sw_en,
  input  wire logic [W-1:0] i_sw_val,
  output logic      [W-1:0] o_pin
);
  logic [W-1:0] float_q = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Undriven pins toggle, so a stale level never passes for a real one
  always_ff @(posedge i_clock) begin
    float_q <= ~float_q;
  end

  // Driver beats switch beats resistors; pull-up wins over pull-down
  // resistor levels
  always_comb begin
    for (int n = 0; n < W; n++) begin
      if (i_oe[n]) o_pin[n] = i_out[n];
      else if (i_sw_en[n]) o_pin[n] = i_sw_val[n];
      else if (i_pullup[n] | i_fixed_pu[n]) o_pin[n] = 1'b1;
      else if (i_fixed_pd[n]) o_pin[n] = 1'b0;
      else o_pin[n] = float_q[n];
    end
  end
endmodule : gio_pin_model

// ### tb/gio_top_bench.sv
`timescale 1ns/10ps
`include "gio_defs.svh"

module gio_top_bench;
  logic                     clock, rst_b, wdt, wr_en, rd_en, wake_req;
  gio_pkg::gio_power_mode_t mode;
  logic [`GIO_ADDR_W-1:0]   addr;
  logic [7:0]               wdata, rdata, gpio_sel;
  logic [7:0]               pin_a, allow_a, out_a, oe_a, pu_a, sw_en_a, sw_a;
  logic [7:0]               pin_b, allow_b, out_b, oe_b, pu_b, sw_en_b, sw_b, fpu_b, fpd_b;
  logic [1:0]               pin_c, allow_c, out_c, oe_c, pu_c, sw_en_c, sw_c;
  logic [7:0]               fix_a;
  int                       miscompares = 0;
  int                       n_checks = 0;
  localparam logic [7:0] RST_EXP [0:15] = '{8'ha5, 8'hff, 8'h00, 8'h00, 8'h3c, 8'hff,
    8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ////////////////////////////////////////////////////////////////////////////////
  gio_top u_dut (.i_clock(clock), .i_rst_b(rst_b), .i_wdt_timeout(wdt), .i_power_mode(mode),
    .i_addr(addr), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_wdata(wdata), .o_rdata(rdata),
    .i_port_a_pin(pin_a), .i_port_a_pu_allow(allow_a), .i_port_a_gpio_sel(gpio_sel),
    .o_port_a_out(out_a), .o_port_a_oe(oe_a), .o_port_a_pullup(pu_a),
    .i_port_b_pin(pin_b), .i_port_b_pu_allow(allow_b), .o_port_b_out(out_b),
    .o_port_b_oe(oe_b), .o_port_b_pullup(pu_b), .o_port_b_fixed_pullup(fpu_b),
    .o_port_b_fixed_pulldown(fpd_b), .i_port_c_pin(pin_c), .i_port_c_pu_allow(allow_c),
    .o_port_c_out(out_c), .o_port_c_oe(oe_c), .o_port_c_pullup(pu_c), .o_wake_req(wake_req));

  // One pin model per port, far side of the pads
  // Port A has no fixed resistors; its model sees an all-zero bench variable
  gio_pin_model u_pins_a (.i_clock(clock), .i_out(out_a), .i_oe(oe_a),
    .i_pullup(pu_a), .i_fixed_pu(fix_a), .i_fixed_pd(fix_a), .i_sw_en(sw_en_a),
    .i_sw_val(sw_a), .o_pin(pin_a));
  gio_pin_model u_pins_b (.i_clock(clock), .i_out(out_b), .i_oe(oe_b),
    .i_pullup(pu_b), .i_fixed_pu(fpu_b), .i_fixed_pd(fpd_b), .i_sw_en(sw_en_b),
    .i_sw_val(sw_b), .o_pin(pin_b));
  gio_pin_model #(.W(2)) u_pins_c (.i_clock(clock), .i_out(out_c), .i_oe(oe_c),
    .i_pullup(pu_c), .i_fixed_pu(2'h0), .i_fixed_pd(2'h0), .i_sw_en(sw_en_c),
    .i_sw_val(sw_c), .o_pin(pin_c));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  // Accesses start at a falling edge; strobe lasts one rising edge,
  // then one idle edge so back-to-back calls never retoggle a strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    check8(rdata, exp);
    @(negedge clock);
  endtask : rd_chk

  // Counts request cycles; a single pulse gives exactly one
  task automatic wake_cnt(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    for (int k = 0; k < 6; k++) begin
      @(negedge clock);
      if (wake_req === 1'b1) n++;
    end
    check8(n, exp);
  endtask : wake_cnt

  task automatic pulse_wdt;
    wdt = 1'b1;
    @(negedge clock);
    wdt = 1'b0;
  endtask : pulse_wdt

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fix_a = 8'h00;
    rst_b = 1'b0; wdt = 1'b0; mode = gio_pkg::gio_mode_fast; addr = '0;
    wr_en = 1'b0; rd_en = 1'b0; wdata = 8'h00; gpio_sel = 8'hff;
    allow_a = 8'hff; allow_b = 8'hff; allow_c = 2'h3;
    sw_en_a = 8'hff; sw_a = 8'ha5; sw_en_b = 8'hff; sw_b = 8'h3c; sw_en_c = 2'h3; sw_c = 2'h2;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    check8(out_a, 8'hff);
    check8(oe_a, 8'h00);
    check8({4'h0, out_c, oe_c}, 8'h0c);
    // Whole map after reset, unmapped indices included
    for (int i = 0; i < 16; i++) rd_chk(4'(i), RST_EXP[i]);
    // High nibble driven, low nibble read from the pins
    wr(`GIO_OFS_A_DIR, 8'h0f);
    wr(`GIO_OFS_A_DATA, 8'h3c);
    sw_a = 8'h5a;
    wr(`GIO_OFS_B_DATA, 8'h00);
    check8(oe_a, 8'hf0);
    check8(out_a, 8'h3c);
    check8(out_b, 8'h00);
    rd_chk(`GIO_OFS_A_DATA, 8'h3a);
    // Pull-up gated by pin sharing
    wr(`GIO_OFS_A_PU, 8'hff);
    allow_a = 8'h0f;
    #1 check8(pu_a, 8'h0f);
    // Port B resistors seen on released pins
    check8(fpu_b, 8'h18);
    check8(fpd_b, 8'h20);
    wr(`GIO_OFS_B_PU, 8'h01);
    wr(`GIO_OFS_B_DIR, 8'h39);
    sw_en_b = 8'h00;
    rd_chk(`GIO_OFS_B_DATA, 8'h19);
    check8(oe_b, 8'hc6);
    check8(pu_b, 8'h01);
    wr(`GIO_OFS_C_DIR, 8'hff);
    rd_chk(`GIO_OFS_C_DIR, 8'h03);
    wr(4'hc, 8'h55);
    rd_chk(4'hc, 8'h00);
    wr(`GIO_OFS_C_PU, 8'hfd);
    check8({6'h00, pu_c}, 8'h01);
    // Watchdog in sleep keeps, in run restores
    mode = gio_pkg::gio_mode_sleep;
    pulse_wdt();
    rd_chk(`GIO_OFS_A_DIR, 8'h0f);
    rd_chk(`GIO_OFS_A_PU, 8'hff);
    mode = gio_pkg::gio_mode_fast;
    pulse_wdt();
    rd_chk(`GIO_OFS_A_DIR, 8'hff);
    rd_chk(`GIO_OFS_B_PU, 8'h00);
    check8(out_a, 8'hff);
    // Wake on armed pin zero, once per stay
    wr(`GIO_OFS_A_WAKE, 8'h01);
    sw_a = 8'hff;
    mode = gio_pkg::gio_mode_sleep;
    repeat (3) @(negedge clock);
    sw_a = 8'hfe;
    wake_cnt(8'h01);
    sw_a = 8'hff;
    repeat (2) @(negedge clock);
    sw_a = 8'hfe;
    wake_cnt(8'h00);
    // New stay: unarmed pin, then non-GPIO function
    mode = gio_pkg::gio_mode_fast;
    sw_a = 8'hff;
    repeat (2) @(negedge clock);
    mode = gio_pkg::gio_mode_idle;
    repeat (3) @(negedge clock);
    sw_a = 8'hfd;
    wake_cnt(8'h00);
    sw_a = 8'hff;
    gpio_sel = 8'hfe;
    repeat (2) @(negedge clock);
    sw_a = 8'hfe;
    wake_cnt(8'h00);
    sw_a = 8'hff;
    gpio_sel = 8'hff;
    repeat (2) @(negedge clock);
    sw_a = 8'hfe;
    wake_cnt(8'h01);
    // Run mode never wakes
    mode = gio_pkg::gio_mode_fast;
    sw_a = 8'hff;
    repeat (2) @(negedge clock);
    sw_a = 8'hfe;
    wake_cnt(8'h00);
    print_verdict();
  end
endmodule : gio_top_bench
